// [design/msb_regs.svh]
// Constants of the multidrop scan bridge: instruction codes, widths, addresses.
// Assumes an 8-bit instruction register and a 6-bit static slot address.
`ifndef MSB_REGS_SVH
`define MSB_REGS_SVH
`define MSB_IR_W 8
`define MSB_SLOT_W 6
`define MSB_NPORT 3
`define MSB_MODE_W 8
`define MSB_ADDR_BCAST 6'h3B
`define MSB_ADDR_GRP_BASE 6'h3C
`define MSB_IR_CAPTURE 8'h01
`define MSB_IR_RESET 8'hFF
`define MSB_CMD_BYPASS 8'hFF
`define MSB_CMD_EXTEST 8'h00
`define MSB_CMD_SAMPLE 8'h81
`define MSB_CMD_IDCODE 8'hAA
`define MSB_CMD_SELECT_MODE_REG_CMD 8'h8E
`define MSB_CMD_SELECT_GROUP_REG_CMD 8'h03
`define MSB_CMD_SELECT_SIGNATURE_REG_CMD 8'hC9
`define MSB_CMD_SELECT_COUNTER_REG_CMD 8'hCE
`define MSB_CMD_SIGNATURE_ON_CMD 8'h0C
`define MSB_CMD_SIGNATURE_OFF_CMD 8'h0D
`define MSB_CMD_COUNTER_ON_CMD 8'h0E
`define MSB_CMD_COUNTER_OFF_CMD 8'h0F
`define MSB_CMD_RETURN_TO_WAIT_CMD 8'hC3
`define MSB_CMD_PARKTLR 8'hC4
`define MSB_CMD_PARK_IN_IDLE_CMD 8'hC5
`define MSB_CMD_PARKPAUSE 8'hC6
`define MSB_CMD_UNPARK 8'hC7
`define MSB_MODE_RESET 8'h01
`define MSB_ID_RESET 32'h00000001
`endif

// [design/msb_pkg.sv]
// Types shared by the multidrop scan bridge control logic.
// Assumes msb_regs.svh supplies all numeric constants.
package msb_pkg;
	typedef enum logic [15:0] {
		TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SELDR = 16'h0004,
		TAP_CAPDR = 16'h0008, TAP_SHDR = 16'h0010, TAP_EX1DR = 16'h0020,
		TAP_PADR = 16'h0040, TAP_EX2DR = 16'h0080, TAP_UPDR = 16'h0100,
		TAP_SELIR = 16'h0200, TAP_CAPIR = 16'h0400, TAP_SHIR = 16'h0800,
		TAP_EX1IR = 16'h1000, TAP_PAIR = 16'h2000, TAP_EX2IR = 16'h4000,
		TAP_UPIR = 16'h8000
	} msb_tap_t;
	typedef enum logic [3:0] {
		SEL_WAIT = 4'h1, SEL_SINGLE = 4'h2, SEL_MULTI = 4'h4, SEL_UNSEL = 4'h8
	} msb_sel_t;
	typedef enum logic [4:0] {
		PRT_TLR = 5'h01, PRT_RTI = 5'h02, PRT_PDR = 5'h04, PRT_PIR = 5'h08,
		PRT_UNPARK = 5'h10
	} msb_port_t;
	typedef struct packed {
		logic [2:0] clk;
		logic [2:0] tms;
		logic [2:0] tdo;
		logic [2:0] oe;
	} msb_local_out_t;
endpackage

// [design/msb_bridge.sv]
// Control logic of the multidrop scan bridge: tap, selection, port machines.
// Assumes backplane signals are asynchronous pins, sampled by clk_sys.
`timescale 1ns/1ps
`include "msb_regs.svh"
module msb_bridge #(
	parameter int NPORT = `MSB_NPORT,
	parameter logic [31:0] ID_VALUE = `MSB_ID_RESET // Arbitrary identity value.
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic backplane_test_clock,
	input wire logic backplane_mode_select,
	input wire logic backplane_data_in,
	input wire logic test_reset_n,
	input wire logic [`MSB_SLOT_W-1:0] slot_id,
	input wire logic local_port_disable,
	input wire logic [NPORT-1:0] local_data_in,
	output logic backplane_data_out,
	output logic backplane_data_out_oe,
	output msb_pkg::msb_local_out_t local_port_network,
	output logic [3:0] cmd_flags,
	output msb_pkg::msb_sel_t sel_state,
	output msb_pkg::msb_tap_t tap_state
);
	// Two-stage synchronisers; the first stage feeds only the second.
	logic [5:0] sy1_reg, sy1_next, sy2_reg, sy2_next;
	logic [NPORT-1:0] ld1_reg, ld1_next, ld2_reg, ld2_next;
	logic tck_q_reg, tck_q_next;
	logic tck, tms, tdi, trst_n;
	logic rise, fall;

	always_comb begin
		sy1_next = {local_port_disable, test_reset_n, backplane_data_in,
			backplane_mode_select, backplane_test_clock, 1'b0};
		sy2_next = sy1_reg;
		ld1_next = local_data_in;
		ld2_next = ld1_reg;
		tck_q_next = sy2_reg[1];
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sy1_reg <= 6'h00;
			sy2_reg <= 6'h00;
			ld1_reg <= '0;
			ld2_reg <= '0;
			tck_q_reg <= 1'b0;
		end else begin
			sy1_reg <= sy1_next;
			sy2_reg <= sy2_next;
			ld1_reg <= ld1_next;
			ld2_reg <= ld2_next;
			tck_q_reg <= tck_q_next;
		end
	end
	assign tck = sy2_reg[1];
	assign tms = sy2_reg[2];
	assign tdi = sy2_reg[3];
	assign trst_n = sy2_reg[4];
	assign rise = tck & ~tck_q_reg;
	assign fall = ~tck & tck_q_reg;

	function automatic msb_pkg::msb_tap_t tap_step(msb_pkg::msb_tap_t s, logic m);
		case (s)
			msb_pkg::TAP_TLR: tap_step = m ? msb_pkg::TAP_TLR : msb_pkg::TAP_RTI;
			msb_pkg::TAP_RTI: tap_step = m ? msb_pkg::TAP_SELDR : msb_pkg::TAP_RTI;
			msb_pkg::TAP_SELDR: tap_step = m ? msb_pkg::TAP_SELIR : msb_pkg::TAP_CAPDR;
			msb_pkg::TAP_CAPDR: tap_step = m ? msb_pkg::TAP_EX1DR : msb_pkg::TAP_SHDR;
			msb_pkg::TAP_SHDR: tap_step = m ? msb_pkg::TAP_EX1DR : msb_pkg::TAP_SHDR;
			msb_pkg::TAP_EX1DR: tap_step = m ? msb_pkg::TAP_UPDR : msb_pkg::TAP_PADR;
			msb_pkg::TAP_PADR: tap_step = m ? msb_pkg::TAP_EX2DR : msb_pkg::TAP_PADR;
			msb_pkg::TAP_EX2DR: tap_step = m ? msb_pkg::TAP_UPDR : msb_pkg::TAP_SHDR;
			msb_pkg::TAP_UPDR: tap_step = m ? msb_pkg::TAP_SELDR : msb_pkg::TAP_RTI;
			msb_pkg::TAP_SELIR: tap_step = m ? msb_pkg::TAP_TLR : msb_pkg::TAP_CAPIR;
			msb_pkg::TAP_CAPIR: tap_step = m ? msb_pkg::TAP_EX1IR : msb_pkg::TAP_SHIR;
			msb_pkg::TAP_SHIR: tap_step = m ? msb_pkg::TAP_EX1IR : msb_pkg::TAP_SHIR;
			msb_pkg::TAP_EX1IR: tap_step = m ? msb_pkg::TAP_UPIR : msb_pkg::TAP_PAIR;
			msb_pkg::TAP_PAIR: tap_step = m ? msb_pkg::TAP_EX2IR : msb_pkg::TAP_PAIR;
			msb_pkg::TAP_EX2IR: tap_step = m ? msb_pkg::TAP_UPIR : msb_pkg::TAP_SHIR;
			msb_pkg::TAP_UPIR: tap_step = m ? msb_pkg::TAP_SELDR : msb_pkg::TAP_RTI;
			default: tap_step = msb_pkg::TAP_TLR;
		endcase
	endfunction

	// The test reset pin is a level here, so it acts after the synchroniser delay.
	logic soft_rst;
	assign soft_rst = ~trst_n;

	msb_pkg::msb_tap_t tap_reg, tap_next;
	msb_pkg::msb_sel_t sel_reg, sel_next;
	msb_pkg::msb_port_t prt_reg [NPORT], prt_next [NPORT];
	logic [`MSB_IR_W-1:0] ir_sh_reg, ir_sh_next, ir_reg, ir_next;
	logic [`MSB_MODE_W-1:0] mode_sh_reg, mode_sh_next, mode_reg, mode_next;
	logic [31:0] dr_sh_reg, dr_sh_next;
	logic [3:0] flags_reg, flags_next;
	logic [NPORT-1:0] pad_reg, pad_next;
	logic tdo_reg, tdo_next, oe_reg, oe_next;
	logic [NPORT-1:0] ins;
	logic [NPORT:0] chain;
	logic selected, upd_ir, dr_sel_mode;

	assign selected = (sel_reg == msb_pkg::SEL_SINGLE) || (sel_reg == msb_pkg::SEL_MULTI);
	assign upd_ir = rise && (tap_reg == msb_pkg::TAP_UPIR);
	assign dr_sel_mode = (ir_reg == `MSB_CMD_SELECT_MODE_REG_CMD);

	// Inserted ports are unparked ports enabled in the mode register.
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			ins[i] = (prt_reg[i] == msb_pkg::PRT_UNPARK) && mode_reg[i];
		end
	end

	// One chain: bridge register, then each inserted port through its pad bit.
	always_comb begin
		chain[0] = dr_sel_mode ? mode_sh_reg[0] : dr_sh_reg[0];
		for (int i = 0; i < NPORT; i++) begin
			chain[i+1] = ins[i] ? pad_reg[i] : chain[i];
		end
	end

	always_comb begin
		tap_next = tap_reg;
		ir_sh_next = ir_sh_reg;
		ir_next = ir_reg;
		mode_sh_next = mode_sh_reg;
		mode_next = mode_reg;
		dr_sh_next = dr_sh_reg;
		flags_next = flags_reg;
		if (rise) begin
			tap_next = tap_step(tap_reg, tms);
			case (tap_reg)
				msb_pkg::TAP_TLR: ir_next = `MSB_IR_RESET;
				msb_pkg::TAP_CAPIR: ir_sh_next = `MSB_IR_CAPTURE;
				msb_pkg::TAP_SHIR: ir_sh_next = {tdi, ir_sh_reg[`MSB_IR_W-1:1]};
				msb_pkg::TAP_UPIR: ir_next = ir_sh_reg;
				msb_pkg::TAP_CAPDR: begin
					mode_sh_next = mode_reg;
					dr_sh_next = (ir_reg == `MSB_CMD_IDCODE) ? ID_VALUE : 32'h00000000;
				end
				msb_pkg::TAP_SHDR: begin
					mode_sh_next = {tdi, mode_sh_reg[`MSB_MODE_W-1:1]};
					dr_sh_next = {tdi, dr_sh_reg[31:1]};
				end
				msb_pkg::TAP_UPDR: if (dr_sel_mode && selected) mode_next = mode_sh_reg;
				default: ;
			endcase
			// Only one register select is live at a time, so each select clears the other.
			if (upd_ir && selected) begin
				case (ir_sh_reg)
					`MSB_CMD_SIGNATURE_ON_CMD: flags_next[0] = 1'b1;
					`MSB_CMD_SIGNATURE_OFF_CMD: flags_next[0] = 1'b0;
					`MSB_CMD_COUNTER_ON_CMD: flags_next[1] = 1'b1;
					`MSB_CMD_COUNTER_OFF_CMD: flags_next[1] = 1'b0;
					`MSB_CMD_SELECT_GROUP_REG_CMD: flags_next[3:2] = 2'b01;
					`MSB_CMD_SELECT_SIGNATURE_REG_CMD, `MSB_CMD_SELECT_COUNTER_REG_CMD: flags_next[3:2] = 2'b10;
					`MSB_CMD_BYPASS, `MSB_CMD_EXTEST, `MSB_CMD_SAMPLE: flags_next[3:2] = 2'b00;
					default: ;
				endcase
			end
		end
	end

	// Selection machine; the compare uses the freshly updated instruction bits.
	always_comb begin
		sel_next = sel_reg;
		if (tap_reg == msb_pkg::TAP_TLR) begin
			sel_next = msb_pkg::SEL_WAIT;
		end else if (upd_ir) begin
			case (sel_reg)
				msb_pkg::SEL_WAIT: begin
					if (ir_sh_reg[`MSB_SLOT_W-1:0] == slot_id) sel_next = msb_pkg::SEL_SINGLE;
					else if (ir_sh_reg[`MSB_SLOT_W-1:0] == `MSB_ADDR_BCAST) sel_next = msb_pkg::SEL_MULTI;
					else sel_next = msb_pkg::SEL_UNSEL;
				end
				msb_pkg::SEL_SINGLE, msb_pkg::SEL_MULTI: begin
					if (ir_sh_reg == `MSB_CMD_RETURN_TO_WAIT_CMD) sel_next = msb_pkg::SEL_WAIT;
				end
				msb_pkg::SEL_UNSEL: ;
				default: sel_next = msb_pkg::SEL_WAIT;
			endcase
		end
	end

	// Port machines: identical, independent, gated by selection and tap state.
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			prt_next[i] = prt_reg[i];
			if (rise && selected) begin
				case (prt_reg[i])
					msb_pkg::PRT_UNPARK: begin
						if (ir_reg == `MSB_CMD_PARK_IN_IDLE_CMD && tap_reg == msb_pkg::TAP_RTI)
							prt_next[i] = msb_pkg::PRT_RTI;
						else if (ir_reg == `MSB_CMD_PARKTLR && tap_reg == msb_pkg::TAP_RTI)
							prt_next[i] = msb_pkg::PRT_TLR;
						else if (ir_reg == `MSB_CMD_PARKPAUSE && tap_reg == msb_pkg::TAP_PADR)
							prt_next[i] = msb_pkg::PRT_PDR;
						else if (ir_reg == `MSB_CMD_PARKPAUSE && tap_reg == msb_pkg::TAP_PAIR)
							prt_next[i] = msb_pkg::PRT_PIR;
					end
					msb_pkg::PRT_TLR, msb_pkg::PRT_RTI: begin
						if (ir_reg == `MSB_CMD_UNPARK && mode_reg[i] &&
							tap_step(tap_reg, tms) == msb_pkg::TAP_RTI)
							prt_next[i] = msb_pkg::PRT_UNPARK;
					end
					msb_pkg::PRT_PDR: begin
						if (ir_reg == `MSB_CMD_UNPARK && mode_reg[i] &&
							tap_step(tap_reg, tms) == msb_pkg::TAP_PADR)
							prt_next[i] = msb_pkg::PRT_UNPARK;
					end
					msb_pkg::PRT_PIR: begin
						if (ir_reg == `MSB_CMD_UNPARK && mode_reg[i] &&
							tap_step(tap_reg, tms) == msb_pkg::TAP_PAIR)
							prt_next[i] = msb_pkg::PRT_UNPARK;
					end
					default: prt_next[i] = msb_pkg::PRT_TLR;
				endcase
			end
		end
	end

	// Data out changes on the falling edge, as the standard expects.
	always_comb begin
		pad_next = pad_reg;
		tdo_next = tdo_reg;
		oe_next = oe_reg;
		if (rise) begin
			for (int i = 0; i < NPORT; i++) begin
				pad_next[i] = ld2_reg[i];
			end
		end
		if (fall) begin
			oe_next = (sel_reg == msb_pkg::SEL_SINGLE) &&
				(tap_reg == msb_pkg::TAP_SHDR || tap_reg == msb_pkg::TAP_SHIR);
			tdo_next = (tap_reg == msb_pkg::TAP_SHIR) ? ir_sh_reg[0] : chain[NPORT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tap_reg <= msb_pkg::TAP_TLR;
			sel_reg <= msb_pkg::SEL_WAIT;
			for (int i = 0; i < NPORT; i++) prt_reg[i] <= msb_pkg::PRT_TLR;
			ir_sh_reg <= `MSB_IR_RESET;
			ir_reg <= `MSB_IR_RESET;
			mode_sh_reg <= `MSB_MODE_RESET;
			mode_reg <= `MSB_MODE_RESET;
			dr_sh_reg <= 32'h00000000;
			flags_reg <= 4'h0;
			pad_reg <= '0;
			tdo_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else if (soft_rst) begin
			tap_reg <= msb_pkg::TAP_TLR;
			sel_reg <= msb_pkg::SEL_WAIT;
			for (int i = 0; i < NPORT; i++) prt_reg[i] <= msb_pkg::PRT_TLR;
			ir_sh_reg <= `MSB_IR_RESET;
			ir_reg <= `MSB_IR_RESET;
			mode_sh_reg <= `MSB_MODE_RESET;
			mode_reg <= `MSB_MODE_RESET;
			dr_sh_reg <= 32'h00000000;
			flags_reg <= 4'h0;
			pad_reg <= '0;
			tdo_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			tap_reg <= tap_next;
			sel_reg <= sel_next;
			for (int i = 0; i < NPORT; i++) prt_reg[i] <= prt_next[i];
			ir_sh_reg <= ir_sh_next;
			ir_reg <= ir_next;
			mode_sh_reg <= mode_sh_next;
			mode_reg <= mode_next;
			dr_sh_reg <= dr_sh_next;
			flags_reg <= flags_next;
			pad_reg <= pad_next;
			tdo_reg <= tdo_next;
			oe_reg <= oe_next;
		end
	end

	// Local pins: the clock is the sampled backplane clock, so it lags by the sync delay.
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			local_port_network.clk[i] = tck;
			local_port_network.tms[i] = (prt_reg[i] == msb_pkg::PRT_UNPARK) ? tms :
				(prt_reg[i] == msb_pkg::PRT_TLR);
			local_port_network.tdo[i] = chain[i];
			local_port_network.oe[i] = ~sy2_reg[5];
		end
	end

	assign backplane_data_out = tdo_reg;
	assign backplane_data_out_oe = oe_reg;
	assign cmd_flags = flags_reg;
	assign sel_state = sel_reg;
	assign tap_state = tap_reg;

	property p_reset_tlr;
		@(posedge clk_sys) disable iff (!rst_n) soft_rst |=> tap_reg == msb_pkg::TAP_TLR;
	endproperty
	a_reset_tlr: assert property (p_reset_tlr) else $error("tap not reset");

	property p_sel_wait;
		@(posedge clk_sys) disable iff (!rst_n)
			(tap_reg == msb_pkg::TAP_TLR && !soft_rst) |=> sel_reg == msb_pkg::SEL_WAIT;
	endproperty
	a_sel_wait: assert property (p_sel_wait) else $error("selection not waiting");

	property p_rti_hold;
		@(posedge clk_sys) disable iff (!rst_n)
			prt_reg[0] == msb_pkg::PRT_RTI |-> local_port_network.tms[0] == 1'b0;
	endproperty
	a_rti_hold: assert property (p_rti_hold) else $error("parked mode select not low");

	property p_unsel_frozen;
		@(posedge clk_sys) disable iff (!rst_n)
			(!selected && !soft_rst) |=> $stable(prt_reg[1]);
	endproperty
	a_unsel_frozen: assert property (p_unsel_frozen) else $error("port moved unselected");

	property p_unpark_rti;
		@(posedge clk_sys) disable iff (!rst_n)
			($past(prt_reg[0]) == msb_pkg::PRT_RTI && prt_reg[0] == msb_pkg::PRT_UNPARK)
			|-> tap_reg == msb_pkg::TAP_RTI;
	endproperty
	a_unpark_rti: assert property (p_unpark_rti) else $error("unpark off idle");

	property p_clk_copy;
		@(posedge clk_sys) disable iff (!rst_n) local_port_network.clk == {NPORT{tck}};
	endproperty
	a_clk_copy: assert property (p_clk_copy) else $error("local clock differs");

	property p_oe_off;
		@(posedge clk_sys) disable iff (!rst_n)
			sy2_reg[5] |-> local_port_network.oe == '0;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("local ports driven");

	property p_follow;
		@(posedge clk_sys) disable iff (!rst_n)
			prt_reg[0] == msb_pkg::PRT_UNPARK |-> local_port_network.tms[0] == tms;
	endproperty
	a_follow: assert property (p_follow) else $error("mode select not followed");
endmodule

// [testbench/msb_local_chain.sv]
// Behavioural model of the three downstream scan chains behind the local ports.
// Assumes the bridge's local outputs arrive as the package's packed struct.
`timescale 1ns/1ps
module msb_local_chain (
	input wire msb_pkg::msb_local_out_t lpn,
	output logic [2:0] data_back
);
	logic [2:0] q = 3'h7;
	for (genvar i = 0; i < 3; i++) begin : g_port
		// Each chain acts as one bypass stage; an undriven input reads as the pull-up level.
		always @(posedge lpn.clk[i]) begin
			q[i] <= lpn.oe[i] ? lpn.tdo[i] : 1'h1;
		end
		assign data_back[i] = q[i];
	end
endmodule

// [testbench/msb_bridge_tb.sv]
// Self-checking bench for the scan bridge control: tap walk, selection, port parking.
// Assumes the bench clocks the backplane pins from clk_sys at a 160 ns test clock period.
`timescale 1ns/1ps
module msb_bridge_tb;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic tck = 1'h0;
	logic tms = 1'h1;
	logic tdi = 1'h1;
	logic trst_n = 1'h1;
	logic lp_dis = 1'h0;
	logic [5:0] slot = 6'h15;
	logic [2:0] ldi;
	logic bdo;
	logic bdo_oe;
	logic [3:0] flags;
	msb_pkg::msb_local_out_t lpn;
	msb_pkg::msb_sel_t sel;
	msb_pkg::msb_tap_t tap;
	logic [35:0] expq[$];
	logic [35:0] e;
	logic [31:0] seen;
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int ts = 0;
	integer seed = 32'hD7AD;
	// Next tap state index for mode select low and high, in one-hot bit order.
	int nx0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
	int nx1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
	logic [7:0] cmds[8] = '{8'h0C, 8'h0E, 8'h0D, 8'h0F, 8'h03, 8'hC9, 8'hCE, 8'hFF};
	logic [3:0] fl[8] = '{4'h1, 4'h3, 4'h2, 4'h0, 4'h4, 4'h8, 4'h8, 4'h0};

	always #10 clk_sys = ~clk_sys;

	msb_bridge uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .backplane_test_clock(tck),
		.backplane_mode_select(tms), .backplane_data_in(tdi), .test_reset_n(trst_n),
		.slot_id(slot), .local_port_disable(lp_dis), .local_data_in(ldi),
		.backplane_data_out(bdo), .backplane_data_out_oe(bdo_oe),
		.local_port_network(lpn), .cmd_flags(flags), .sel_state(sel), .tap_state(tap)
	);

	msb_local_chain chain (.lpn(lpn), .data_back(ldi));

	task automatic give_verdict();
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			n_errors++;
			$display("BAD t=%0t seen=%h expected=%h", $time, s, x);
		end
	endtask

	task automatic push(input logic [3:0] k, input logic [31:0] v);
		expq.push_back({k, v});
	endtask

	// One test clock period: mode select and data change two ticks after the fall.
	task automatic cyc(input logic m, input logic d);
		tms <= m;
		tdi <= d;
		repeat (2) @(posedge clk_sys);
		push(4'h5, 32'h0);
		tck <= 1'h1;
		repeat (4) @(posedge clk_sys);
		push(4'h5, 32'h7);
		tck <= 1'h0;
		repeat (2) @(posedge clk_sys);
		ts = m ? nx1[ts] : nx0[ts];
		push(4'h0, 32'h1 << ts);
	endtask

	// Scans eight bits, low bit first, from idle; last picks idle or select-DR after update.
	task automatic scan(input logic ir, input logic [7:0] v, input logic oe_x, input logic last);
		cyc(1'h1, 1'h0);
		if (ir) begin
			cyc(1'h1, 1'h0);
		end
		cyc(1'h0, 1'h0);
		cyc(1'h0, 1'h0);
		for (int i = 0; i < 8; i++) begin
			cyc(i == 7, v[i]);
			if (i == 1) begin
				push(4'h4, {31'h0, oe_x});
			end
			// The captured instruction shifts out first, and its two low bits are 01.
			if (ir && oe_x && i < 2) begin
				push(4'h7, {31'h0, (i == 0)});
			end
		end
		cyc(1'h1, 1'h0);
		cyc(last, 1'h0);
	endtask

	// Walks a data-register pass without shifting and checks each local mode select.
	task automatic walk(input logic [2:0] unp, input logic [2:0] hi);
		logic [4:0] pat;
		pat = 5'h0D;
		for (int i = 0; i < 5; i++) begin
			cyc(pat[i], 1'($random(seed)));
			push(4'h2, {29'h0, (unp & {3{pat[i]}}) | hi});
		end
	endtask

	task automatic to_idle();
		repeat (5) cyc(1'h1, 1'h0);
		cyc(1'h0, 1'h0);
	endtask

	always @(negedge clk_sys) begin
		while (expq.size() > 0) begin
			e = expq.pop_front();
			case (e[35:32])
				4'h0: seen = {16'h0, tap};
				4'h1: seen = {28'h0, sel};
				4'h2: seen = {29'h0, lpn.tms};
				4'h3: seen = {29'h0, lpn.oe};
				4'h4: seen = {31'h0, bdo_oe};
				4'h6: seen = {28'h0, flags};
				4'h7: seen = {31'h0, bdo};
				default: seen = {29'h0, lpn.clk};
			endcase
			check(seen, e[31:0]);
		end
	end

	// A hang is cut short well beyond the few thousand cycles the sequence needs.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 12000) begin
			n_errors++;
			give_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk_sys);
		push(4'h0, 32'h1);
		push(4'h1, 32'h1);
		push(4'h2, 32'h7);
		for (int i = 0; i < 48; i++) begin
			cyc(1'($random(seed)), 1'($random(seed)));
		end
		to_idle();
		push(4'h1, 32'h1);
		scan(1'h1, {2'h2, slot ^ 6'h01}, 1'h0, 1'h0);
		push(4'h1, 32'h8);
		scan(1'h1, 8'hC7, 1'h0, 1'h0);
		walk(3'h0, 3'h7);
		to_idle();
		scan(1'h1, 8'hFB, 1'h0, 1'h0);
		push(4'h1, 32'h4);
		to_idle();
		push(4'h1, 32'h1);
		scan(1'h1, {2'h3, slot}, 1'h0, 1'h0);
		push(4'h1, 32'h2);
		scan(1'h1, 8'h8E, 1'h1, 1'h0);
		scan(1'h0, 8'h03, 1'h1, 1'h0);
		scan(1'h1, 8'hC7, 1'h1, 1'h0);
		// The new instruction only acts on the next rising edge that keeps the tap in idle.
		cyc(1'h0, 1'h0);
		walk(3'h3, 3'h4);
		push(4'h3, 32'h7);
		lp_dis <= 1'h1;
		repeat (4) @(posedge clk_sys);
		push(4'h3, 32'h0);
		@(posedge clk_sys);
		lp_dis <= 1'h0;
		scan(1'h1, 8'hC5, 1'h1, 1'h0);
		walk(3'h0, 3'h4);
		scan(1'h1, 8'hC7, 1'h1, 1'h1);
		push(4'h2, 32'h4);
		cyc(1'h0, 1'h0);
		cyc(1'h1, 1'h0);
		cyc(1'h1, 1'h0);
		cyc(1'h0, 1'h0);
		walk(3'h3, 3'h4);
		for (int i = 0; i < 8; i++) begin
			scan(1'h1, cmds[i], 1'h1, 1'h0);
			push(4'h6, {28'h0, fl[i]});
		end
		scan(1'h1, 8'hC3, 1'h1, 1'h0);
		push(4'h1, 32'h1);
		trst_n <= 1'h0;
		repeat (6) @(posedge clk_sys);
		push(4'h0, 32'h1);
		push(4'h1, 32'h1);
		push(4'h2, 32'h7);
		@(posedge clk_sys);
		trst_n <= 1'h1;
		repeat (4) @(posedge clk_sys);
		give_verdict();
	end
endmodule
